// ===== logic/lcd_regs_defs.svh
// Register indices, field positions, reset values and timing figures
`ifndef LCD_REGS_DEFS_SVH
`define LCD_REGS_DEFS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_PANEL_CFG   17'h1FFE1
`define IDX_CLK_CFG     17'h1FFE2
`define IDX_HSIZE       17'h1FFE4
`define IDX_VSIZE_LO    17'h1FFE5
`define IDX_VSIZE_HI    17'h1FFE6
`define IDX_HBLANK      17'h1FFE8
`define IDX_VBLANK      17'h1FFEA
`define IDX_FRAME_0     17'h1FFED
`define IDX_FRAME_1     17'h1FFEE
`define IDX_FRAME_2     17'h1FFEF
`define IDX_GP_DIR      17'h1FFF8
`define IDX_GP_LEVEL    17'h1FFF9
`define IDX_SCRATCH     17'h1FFFA
`define IDX_ROT_MODE    17'h1FFFB
`define IDX_STRIDE      17'h1FFFC
`define IDX_TEST_A      17'h1FFFE
`define IDX_TEST_B      17'h1FFFF

// ---------------------------------------------------------------
// Field positions and writable masks
// ---------------------------------------------------------------
`define ROT_EN_BIT      7
`define ROT_ALT_BIT     6
`define ROT_CLK_LSB     0
`define ROT_MODE_MASK   8'hC3
`define CLK_IN_DIV_BIT  4
`define CLK_MEM_DIV_BIT 5
`define CLK_CFG_MASK    8'h30
`define PANEL_DUAL_BIT  0
`define PANEL_AM_BIT    1
`define PANEL_CFG_MASK  8'h03
`define HSIZE_MASK      8'h7F
`define HBLANK_MASK     8'h1F
`define VSIZE_HI_MASK   8'h03
`define VBLANK_MASK     8'h3F
`define GP_MASK         8'h1F
`define GP_COUNT        5
`define UPPER_PINS      4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_BYTE        8'h00

// ---------------------------------------------------------------
// Frame timing arithmetic
// ---------------------------------------------------------------
`define HDP_UNIT        8
`define HORIZ_BLANK_PERIOD_OFFSET     4
`define STRIDE_ZERO     9'h100

`endif

// ===== logic/lcd_regs_pkg.sv
// Types shared by the register bank and its helpers
package lcd_regs_pkg;

  typedef enum logic [1:0] {
    MODE_LAND = 2'b00,
    MODE_DEF  = 2'b01,
    MODE_ALT  = 2'b11
  } rot_mode_t;

  typedef logic [1:0] div_sel_t;
  typedef logic [7:0] reg_byte_t;

endpackage

// ===== logic/clk_en_gen.sv
// Pixel and memory clock enables divided from the system clock
`timescale 1ns/100ps
module clk_en_gen
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     reset,
  // Divider settings
  input  wire logic     in_half,
  input  wire div_sel_t pclk_sel,
  input  wire div_sel_t mclk_sel,
  // Enable pulses
  output logic          pclk_en,
  output logic          mclk_en
);

  logic       half_r;
  logic [2:0] cnt_r;
  logic       base_en;
  div_sel_t   sel [2];
  logic [1:0] en_r;

  // Base rate is every cycle or every other cycle
  assign base_en = ~in_half | half_r;
  assign sel[0]  = pclk_sel;
  assign sel[1]  = mclk_sel;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_r <= 1'b0;
      cnt_r  <= 3'h0;
    end else begin
      half_r <= ~half_r;
      if (base_en) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  // One shared counter keeps both enables phase aligned
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_en
      logic [2:0] mask;
      assign mask = 3'((4'h1 << sel[i]) - 4'h1);
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          en_r[i] <= 1'b0;
        end else begin
          en_r[i] <= base_en & ((cnt_r & mask) == mask);
        end
      end
    end
  endgenerate

  assign pclk_en = en_r[0];
  assign mclk_en = en_r[1];

endmodule

// ===== logic/frame_len_calc.sv
// Pixel clocks per frame from the display and blanking fields
`timescale 1ns/100ps
`include "lcd_regs_defs.svh"
module frame_len_calc
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Timing fields
  input  wire logic [6:0]  hsize,
  input  wire logic [4:0]  hblank,
  input  wire logic [9:0]  vsize,
  input  wire logic [5:0]  vblank,
  input  wire logic        dual,
  // Result
  output logic      [21:0] frame_pclks
);

  logic [10:0] horiz_display_period;
  logic [10:0] horiz_blank_period;
  logic [10:0] htot;
  logic [10:0] vert_display_period;
  logic [10:0] vlines;
  logic [21:0] prod;

  assign horiz_display_period    = 11'((hsize + 11'd1) * `HDP_UNIT);
  assign horiz_blank_period   = 11'((hblank + 11'd`HORIZ_BLANK_PERIOD_OFFSET) * `HDP_UNIT);
  assign htot   = horiz_display_period + horiz_blank_period;
  assign vert_display_period    = 11'(vsize) + 11'd1;
  // blank lines unchanged, dual halves display
  assign vlines = dual ? (11'(vert_display_period[10:1]) + 11'(vblank))
                       : (vert_display_period + 11'(vblank));
  assign prod   = 22'(htot) * 22'(vlines);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_pclks <= 22'h0;
    end else begin
      frame_pclks <= dual ? {prod[20:0], 1'b0} : prod;
    end
  end

endmodule

// ===== logic/lcd_cfg_regs.sv
// Display controller configuration registers over classic Wishbone
//
// Overview of operation
// - Direction bit 0 input, 1 output
// - Input pin level reads back
// - Output pin drives written level
// - Panel data function overrides pin bits 0 to 3
// - Scratch byte stored, affects nothing
// - Bit 7 enables rotated display
// - Bit 6 picks default or alternate
// - Landscape pixel clock base, memory separate
// - Default rotated divides both equally
// - Alternate rotated memory twice pixel
// - Input divide bit halves base
// - Stride zero means 256 bytes
// - Nonzero stride used as is
// - Display width (field+1) times 8
// - Blank width (field+4) times 8
// - Display lines ten-bit value plus one
// - Blank lines equal field value
// - Single panel frame is product
// - Dual panel frame uses half lines
`timescale 1ns/100ps
`include "lcd_regs_defs.svh"
module lcd_cfg_regs
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [31:0]             adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // General-purpose pins
  input  wire logic [`GP_COUNT-1:0]    gp_in,
  output logic      [`GP_COUNT-1:0]    gp_out,
  output logic      [`GP_COUNT-1:0]    gp_oe_n,
  // Upper panel data from the display pipeline
  input  wire logic [`UPPER_PINS-1:0]  upper_panel_data_pins,
  // Display engine controls
  output logic                         rotate_en,
  output logic                         rotate_alt,
  output logic      [8:0]              line_stride,
  output logic                         active_matrix_panel,
  output logic                         dual_panel,
  output logic                         pclk_en,
  output logic                         mclk_en,
  output logic      [21:0]             frame_pclks
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  reg_byte_t panel_cfg_r;
  reg_byte_t clk_cfg_r;
  reg_byte_t hsize_r;
  reg_byte_t vsize_lo_r;
  reg_byte_t vsize_hi_r;
  reg_byte_t hblank_r;
  reg_byte_t vblank_r;
  reg_byte_t gp_dir_r;
  reg_byte_t gp_level_r;
  reg_byte_t scratch_r;
  reg_byte_t rot_mode_r;
  reg_byte_t stride_r;

  logic [`GP_COUNT-1:0] gp_in_r;
  logic [`GP_COUNT-1:0] gp_out_r;
  logic [`GP_COUNT-1:0] gp_oe_n_r;
  logic                 ack_r;
  logic [31:0]          dat_r;
  logic                 rotate_en_r;
  logic                 rotate_alt_r;
  logic [8:0]           line_stride_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic      req;
  logic      wr_now;
  logic      in_range;
  logic [16:0] idx;
  reg_byte_t wdat;
  reg_byte_t rd_byte;
  reg_byte_t gp_read;
  logic [21:0] frame_w;

  assign req      = cyc_i & stb_i;
  // Register changes at the edge where the master sees ack
  assign wr_now   = req & ack_r & we_i & sel_i[0];
  assign in_range = (adr_i[31:19] == 13'h0) & (adr_i[1:0] == 2'h0);
  assign idx      = adr_i[18:2];
  assign wdat     = dat_i[7:0];

  logic wr_panel;
  logic wr_clk;
  logic wr_hsize;
  logic wr_vlo;
  logic wr_vhi;
  logic wr_hblank;
  logic wr_vblank;
  logic wr_gp_dir;
  logic wr_gp_lvl;
  logic wr_scratch;
  logic wr_rot;
  logic wr_stride;

  assign wr_panel   = wr_now & in_range & (idx == `IDX_PANEL_CFG);
  assign wr_clk     = wr_now & in_range & (idx == `IDX_CLK_CFG);
  assign wr_hsize   = wr_now & in_range & (idx == `IDX_HSIZE);
  assign wr_vlo     = wr_now & in_range & (idx == `IDX_VSIZE_LO);
  assign wr_vhi     = wr_now & in_range & (idx == `IDX_VSIZE_HI);
  assign wr_hblank  = wr_now & in_range & (idx == `IDX_HBLANK);
  assign wr_vblank  = wr_now & in_range & (idx == `IDX_VBLANK);
  assign wr_gp_dir  = wr_now & in_range & (idx == `IDX_GP_DIR);
  assign wr_gp_lvl  = wr_now & in_range & (idx == `IDX_GP_LEVEL);
  assign wr_scratch = wr_now & in_range & (idx == `IDX_SCRATCH);
  assign wr_rot     = wr_now & in_range & (idx == `IDX_ROT_MODE);
  assign wr_stride  = wr_now & in_range & (idx == `IDX_STRIDE);

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // masks drop writes to unused positions
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      panel_cfg_r <= `RST_BYTE;
      clk_cfg_r   <= `RST_BYTE;
      hsize_r     <= `RST_BYTE;
      vsize_lo_r  <= `RST_BYTE;
      vsize_hi_r  <= `RST_BYTE;
      hblank_r    <= `RST_BYTE;
      vblank_r    <= `RST_BYTE;
    end else begin
      if (wr_panel)  panel_cfg_r <= wdat & `PANEL_CFG_MASK;
      if (wr_clk)    clk_cfg_r   <= wdat & `CLK_CFG_MASK;
      if (wr_hsize)  hsize_r     <= wdat & `HSIZE_MASK;
      if (wr_vlo)    vsize_lo_r  <= wdat;
      if (wr_vhi)    vsize_hi_r  <= wdat & `VSIZE_HI_MASK;
      if (wr_hblank) hblank_r    <= wdat & `HBLANK_MASK;
      if (wr_vblank) vblank_r    <= wdat & `VBLANK_MASK;
    end
  end

  // Reserved bits 2 to 5 are dropped, so a careless write cannot leak into
  // the mode decode.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gp_dir_r   <= `RST_BYTE;
      gp_level_r <= `RST_BYTE;
      scratch_r  <= `RST_BYTE;
      rot_mode_r <= `RST_BYTE;
      stride_r   <= `RST_BYTE;
    end else begin
      if (wr_gp_dir)  gp_dir_r   <= wdat & `GP_MASK;
      if (wr_gp_lvl)  gp_level_r <= wdat & `GP_MASK;
      if (wr_scratch) scratch_r  <= wdat;
      if (wr_rot)     rot_mode_r <= wdat & `ROT_MODE_MASK;
      if (wr_stride)  stride_r   <= wdat;
    end
  end

  // ---------------------------------------------------------------
  // Rotation mode and clock selection
  // ---------------------------------------------------------------
  rot_mode_t mode;
  div_sel_t  clk_code;
  div_sel_t  pclk_sel;
  div_sel_t  mclk_sel;

  assign mode = !rot_mode_r[`ROT_EN_BIT] ? MODE_LAND :
                rot_mode_r[`ROT_ALT_BIT] ? MODE_ALT  : MODE_DEF;
  assign clk_code = rot_mode_r[`ROT_CLK_LSB +: 2];

  always_comb begin
    pclk_sel = 2'h0;
    mclk_sel = 2'h0;
    unique case (mode)
      MODE_LAND: begin
        // code ignored, memory follows own bit
        pclk_sel = 2'h0;
        mclk_sel = {1'b0, clk_cfg_r[`CLK_MEM_DIV_BIT]};
      end
      MODE_DEF: begin
        pclk_sel = clk_code;
        mclk_sel = clk_code;
      end
      MODE_ALT: begin
        // memory at twice the pixel rate
        pclk_sel = (clk_code == 2'h0) ? 2'h1 : clk_code;
        mclk_sel = (clk_code == 2'h0) ? 2'h0 : clk_code - 2'h1;
      end
      default: begin
        pclk_sel = 2'h0;
        mclk_sel = 2'h0;
      end
    endcase
  end

  // input divide bit halves base rate
  clk_en_gen u_clk_en (
    .clk      (clk),
    .reset    (reset),
    .in_half  (clk_cfg_r[`CLK_IN_DIV_BIT]),
    .pclk_sel (pclk_sel),
    .mclk_sel (mclk_sel),
    .pclk_en  (pclk_en),
    .mclk_en  (mclk_en)
  );

  // ---------------------------------------------------------------
  // Frame length
  // ---------------------------------------------------------------
  frame_len_calc u_frame (
    .clk         (clk),
    .reset       (reset),
    .hsize       (hsize_r[6:0]),
    .hblank      (hblank_r[4:0]),
    .vsize       ({vsize_hi_r[1:0], vsize_lo_r}),
    .vblank      (vblank_r[5:0]),
    .dual        (panel_cfg_r[`PANEL_DUAL_BIT]),
    .frame_pclks (frame_w)
  );

  assign frame_pclks = frame_w;

  // ---------------------------------------------------------------
  // General-purpose pins
  // ---------------------------------------------------------------
  logic am;
  assign am = panel_cfg_r[`PANEL_AM_BIT];

  genvar g;
  generate
    for (g = 0; g < `GP_COUNT; g = g + 1) begin : g_pin
      logic owned;
      // Only the low pins carry panel data
      assign owned = am & (g < `UPPER_PINS);
      // input pins read back their level
      assign gp_read[g] = owned        ? gp_in_r[g] :
                          gp_dir_r[g]  ? gp_level_r[g] : gp_in_r[g];
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          gp_out_r[g]  <= 1'b0;
          gp_oe_n_r[g] <= 1'b1;
        end else if (owned) begin
          // panel data overrides direction and level
          gp_out_r[g]  <= upper_panel_data_pins[g % `UPPER_PINS];
          gp_oe_n_r[g] <= 1'b0;
        end else begin
          gp_out_r[g]  <= gp_level_r[g];
          gp_oe_n_r[g] <= ~gp_dir_r[g];
        end
      end
    end
  endgenerate

  assign gp_read[7:`GP_COUNT] = '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gp_in_r <= '0;
    end else begin
      gp_in_r <= gp_in;
    end
  end

  // ---------------------------------------------------------------
  // Engine control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rotate_en_r   <= 1'b0;
      rotate_alt_r  <= 1'b0;
      line_stride_r <= `STRIDE_ZERO;
    end else begin
      rotate_en_r   <= (mode != MODE_LAND);
      rotate_alt_r  <= (mode == MODE_ALT);
      // zero codes the full 256-byte stride
      line_stride_r <= (stride_r == 8'h00) ? `STRIDE_ZERO
                                           : {1'b0, stride_r};
    end
  end

  assign rotate_en           = rotate_en_r;
  assign rotate_alt          = rotate_alt_r;
  assign line_stride         = line_stride_r;
  assign active_matrix_panel = panel_cfg_r[`PANEL_AM_BIT];
  assign dual_panel          = panel_cfg_r[`PANEL_DUAL_BIT];
  assign gp_out              = gp_out_r;
  assign gp_oe_n             = gp_oe_n_r;

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // test registers drop writes and read zero, so a stray
  // access cannot reach factory logic.
  always_comb begin
    rd_byte = 8'h00;
    if (in_range) begin
      unique case (idx)
        `IDX_PANEL_CFG: rd_byte = panel_cfg_r;
        `IDX_CLK_CFG:   rd_byte = clk_cfg_r;
        `IDX_HSIZE:     rd_byte = hsize_r;
        `IDX_VSIZE_LO:  rd_byte = vsize_lo_r;
        `IDX_VSIZE_HI:  rd_byte = vsize_hi_r;
        `IDX_HBLANK:    rd_byte = hblank_r;
        `IDX_VBLANK:    rd_byte = vblank_r;
        `IDX_FRAME_0:   rd_byte = frame_w[7:0];
        `IDX_FRAME_1:   rd_byte = frame_w[15:8];
        `IDX_FRAME_2:   rd_byte = {2'h0, frame_w[21:16]};
        `IDX_GP_DIR:    rd_byte = gp_dir_r;
        `IDX_GP_LEVEL:  rd_byte = gp_read;
        `IDX_SCRATCH:   rd_byte = scratch_r;
        `IDX_ROT_MODE:  rd_byte = rot_mode_r;
        `IDX_STRIDE:    rd_byte = stride_r;
        default:        rd_byte = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // Every access, mapped or not, answers one cycle after it appears;
  // unmapped reads return zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req & ~ack_r;
      dat_r <= {24'h0, rd_byte};
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

endmodule

// ===== dv/gp_pin_model.sv
// Board-side model of the five general-purpose pins
`timescale 1ns/100ps
module gp_pin_model (
  // Design side
  input  wire logic [4:0] gp_out,
  input  wire logic [4:0] gp_oe_n,
  // External drivers set by the bench
  input  wire logic [4:0] ext_val,
  input  wire logic [4:0] ext_en,
  // Resolved pin levels
  output logic      [4:0] gp_in
);
  // ---------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------
  // direction picks driver
  // Undriven pins are tied high on the board, so they read 1
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!gp_oe_n[i])
        gp_in[i] = gp_out[i];
      else if (ext_en[i])
        gp_in[i] = ext_val[i];
      else
        gp_in[i] = 1'b1;
    end
  end
endmodule

// ===== dv/lcd_cfg_regs_asserts.sv
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
`include "lcd_regs_defs.svh"
module lcd_cfg_regs_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Outputs watched
  input wire logic [4:0]  gp_out,
  input wire logic [4:0]  gp_oe_n,
  input wire logic        rotate_en,
  input wire logic        rotate_alt,
  input wire logic [8:0]  line_stride,
  input wire logic        active_matrix_panel,
  input wire logic        pclk_en,
  input wire logic        mclk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // Decode of the access in its ack cycle
  // ---------------------------------------------------------------
  wire [16:0] idx    = adr_i[18:2];
  wire        ok     = adr_i[31:19] == 13'h0 && adr_i[1:0] == 2'b00;
  wire        wr_ack = ack_o & cyc_i & stb_i & we_i & sel_i[0] & ok;
  wire        rd_ack = ack_o & cyc_i & stb_i & !we_i & ok;
  wire        w_dir  = wr_ack && idx == `IDX_GP_DIR;
  wire        w_lvl  = wr_ack && idx == `IDX_GP_LEVEL;
  wire        w_rot  = wr_ack && idx == `IDX_ROT_MODE;
  wire        w_str  = wr_ack && idx == `IDX_STRIDE;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Pin 4 never belongs to the panel, so it shows the register alone
  property p_dir;
    w_dir |=> ##1 gp_oe_n[4] == !$past(dat_i[4], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit not applied");
  property p_lvl;
    w_lvl |=> ##1 gp_out[4] == $past(dat_i[4], 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("output level not driven");
  property p_am_own;
    active_matrix_panel && $past(active_matrix_panel) |-> gp_oe_n[3:0] == 4'h0;
  endproperty
  a_am_own: assert property (p_am_own) else $error("panel pins not driven");
  property p_rot_en;
    w_rot |=> ##1 rotate_en == $past(dat_i[7], 2);
  endproperty
  a_rot_en: assert property (p_rot_en) else $error("rotate enable wrong");
  property p_rot_alt;
    w_rot |=> ##1 rotate_alt == ($past(dat_i[7], 2) & $past(dat_i[6], 2));
  endproperty
  a_rot_alt: assert property (p_rot_alt) else $error("rotate select wrong");
  property p_stride;
    w_str |=> ##1 line_stride == ($past(dat_i[7:0], 2) == 8'h00 ? 9'h100
                                  : {1'b0, $past(dat_i[7:0], 2)});
  endproperty
  a_stride: assert property (p_stride) else $error("stride value wrong");
  property p_hi_zero;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data not zero");
  property p_rsvd_zero;
    rd_ack && idx == `IDX_ROT_MODE |-> dat_o[5:2] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("unused bits read 1");
  property p_def_eq;
    rotate_en && !rotate_alt && $past(rotate_en) && !$past(rotate_alt)
      |-> pclk_en == mclk_en;
  endproperty
  a_def_eq: assert property (p_def_eq) else $error("default clocks differ");
  c_str0: cover property (w_str && dat_i[7:0] == 8'h00);
  c_alt:  cover property (rotate_alt && mclk_en && !pclk_en);
  c_am:   cover property (active_matrix_panel && ack_o);
endmodule
bind lcd_cfg_regs lcd_cfg_regs_asserts u_chk (.clk, .reset, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .gp_out, .gp_oe_n,
  .rotate_en, .rotate_alt, .line_stride, .active_matrix_panel, .pclk_en,
  .mclk_en);

// ===== dv/lcd_ctrl_gpio_rotation_stride_regs_tb_top.sv
// Self-checking testbench for the configuration register bank
`timescale 1ns/100ps
`include "lcd_regs_defs.svh"
module lcd_ctrl_gpio_rotation_stride_regs_tb_top import lcd_regs_pkg::*;;
  logic        clk, reset, cyc_i, stb_i, we_i, ack_o;
  logic [31:0] adr_i, dat_i, dat_o;
  logic [3:0]  sel_i, upper_panel_data_pins;
  logic        rotate_en, rotate_alt, active_matrix_panel, dual_panel;
  logic        pclk_en, mclk_en;
  logic [4:0]  gp_in, gp_out, gp_oe_n, ext_val, ext_en;
  logic [8:0]  line_stride;
  logic [21:0] frame_pclks;
  int          bad_count, comparisons;

  lcd_cfg_regs DUT (.clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .gp_in, .gp_out, .gp_oe_n,
    .upper_panel_data_pins, .rotate_en, .rotate_alt, .line_stride,
    .active_matrix_panel, .dual_panel, .pclk_en, .mclk_en, .frame_pclks);
  gp_pin_model pins (.gp_out, .gp_oe_n, .ext_val, .ext_en, .gp_in);

  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string s);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // Request held until ack is seen; data taken at that edge only
  task automatic wb(input logic w, input logic [31:0] a, input reg_byte_t d,
                    output reg_byte_t q);
    int n;
    @(posedge clk);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
    dat_i <= {24'h0, d}; sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      chk(0, 1, "no ack");
      results();
    end else begin
      q = dat_o[7:0];
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [16:0] i, input reg_byte_t d);
    reg_byte_t x;
    wb(1'b1, {13'h0, i, 2'b00}, d, x);
    repeat (3) @(posedge clk);
  endtask
  task automatic rc(input logic [16:0] i, input reg_byte_t e, input string s);
    reg_byte_t x;
    wb(1'b0, {13'h0, i, 2'b00}, 8'h00, x);
    chk(x, e, s);
  endtask
  task automatic count(output int p, m);
    repeat (16) @(posedge clk);
    p = 0; m = 0;
    repeat (64) begin
      @(posedge clk);
      p += (pclk_en === 1'b1);
      m += (mclk_en === 1'b1);
    end
  endtask
  task automatic frm(input int hs, hb, v, vb, input logic d);
    int ht, vd, e;
    ht = (hs + 1) * 8 + (hb + 4) * 8;
    vd = v + 1;
    e = d ? 2 * ht * (vd / 2 + vb) : ht * (vd + vb);
    wr(`IDX_HSIZE, hs[7:0]); wr(`IDX_HBLANK, hb[7:0]);
    wr(`IDX_VSIZE_LO, v[7:0]); wr(`IDX_VSIZE_HI, v[15:8]);
    wr(`IDX_VBLANK, vb[7:0]); wr(`IDX_PANEL_CFG, {7'h0, d});
    chk(frame_pclks, e, "frame length");
    chk(dual_panel, d, "dual flag");
    rc(`IDX_FRAME_0, e[7:0], "frame b0");
    rc(`IDX_FRAME_1, e[15:8], "frame b1");
    rc(`IDX_FRAME_2, {2'b00, e[21:16]}, "frame b2");
  endtask
  // ---------------------------------------------------------------
  // Main sequence; factory test registers are never written
  // ---------------------------------------------------------------
  // test registers never written
  initial begin
    int p, m, ep, em, b;
    reg_byte_t x;
    clk = 0; reset = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0;
    dat_i = 0; sel_i = 0; upper_panel_data_pins = 4'hA;
    ext_val = 5'h00; ext_en = 5'h1F; bad_count = 0; comparisons = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    chk(line_stride, 9'h100, "reset stride");
    rc(`IDX_SCRATCH, 8'h00, "scratch reset");
    wr(`IDX_SCRATCH, 8'hA5);
    rc(`IDX_SCRATCH, 8'hA5, "scratch a5");
    wr(`IDX_SCRATCH, 8'h5A);
    rc(`IDX_SCRATCH, 8'h5A, "scratch 5a");
    chk({rotate_en, line_stride}, 10'h100, "scratch effect");
    wb(1'b0, 32'h8000_0000 | {13'h0, 17'(`IDX_SCRATCH), 2'b00}, 8'h00, x);
    chk(x, 8'h00, "unmapped read");
    wr(`IDX_ROT_MODE, 8'hFB);
    rc(`IDX_ROT_MODE, 8'hC3, "rotation bits");
    wr(`IDX_GP_DIR, 8'hFF);
    rc(`IDX_GP_DIR, 8'h1F, "dir bits");
    foreach (x[i]) begin
      wr(`IDX_STRIDE, (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'hFF);
      chk(line_stride, (i == 0) ? 9'h100 : (i == 1) ? 9'h001 : 9'h0FF,
          "stride");
    end
    wr(`IDX_GP_LEVEL, 8'h1A);
    chk({gp_oe_n, gp_out}, 10'h01A, "output pins");
    wr(`IDX_GP_DIR, 8'h00);
    ext_val <= 5'h0B;
    rc(`IDX_GP_LEVEL, 8'h0B, "input 0b");
    ext_val <= 5'h14;
    rc(`IDX_GP_LEVEL, 8'h14, "input 14");
    wr(`IDX_PANEL_CFG, 8'h02);
    wr(`IDX_GP_LEVEL, 8'h05);
    chk({gp_oe_n[3:0], gp_out[3:0]}, 8'h0A, "panel pins");
    chk(gp_oe_n[4], 1'b1, "pin4 stays input");
    chk(active_matrix_panel, 1'b1, "panel flag");
    for (int h = 0; h < 2; h++)
      for (int md = 0; md < 3; md++)
        for (int c = 0; c < 4; c++) begin
          wr(`IDX_CLK_CFG, {2'b00, c[0], h[0], 4'h0});
          wr(`IDX_ROT_MODE, {md != 0, md == 2, 4'h0, c[1:0]});
          count(p, m);
          b = h ? 2 : 1;
          case (md)
            0: begin ep = b; em = c[0] ? 2 * b : b; end
            1: begin ep = b << c; em = ep; end
            default: begin ep = b << ((c == 0) ? 1 : c); em = ep / 2; end
          endcase
          chk(p, 64 / ep, "pclk rate");
          chk(m, 64 / em, "mclk rate");
        end
    frm(127, 31, 1023, 63, 1'b0);
    frm(127, 31, 1023, 63, 1'b1);
    frm(0, 0, 196, 0, 1'b1);
    results();
  end
endmodule
